// ===== hdl/aphp_params.svh
// Notes on behaviour
// - 16-bit two-way bus with select lines.
// - Fresh result gives active-low ready strobe.
// - First read returns upper 16 result bits.
// - Host idles lines one internal clock between reads.
// - Second read returns low byte plus status.
// - Status byte order fixed, two low zeros.
// - Bus released after select lines go high.
// - Both reads finish before next result.
// - Strobe during read marks data invalid.
// - Converts with defaults after reset.
// - Register write is address then data.
// - Write holds chip select four internal clocks.
// - Host waits four internal clocks before data.
// - Read between writes discards latched address.
// - Results after a write invalid for delay.
// - Control select bit picks next readback.
// - Internal clock is master or half.
// - Divider defaults to divide by two.
// - Host isolates data lines from system bus.
// - Valid flag only after group delay.
`ifndef APHP_PARAMS_SVH
`define APHP_PARAMS_SVH
// Device register addresses and control fields.
`define APHP_REG_CTRL      16'h0001
`define APHP_REG_USER      16'h0002
`define APHP_CTRL_CLOCK_DIVIDE_SELECT     0
`define APHP_CTRL_LOW_POWER_FLAG     1
`define APHP_CTRL_USER_FILTER_FLAG    2
`define APHP_CTRL_RB_STAT  3
`define APHP_CTRL_RB_USER  4
`define APHP_CTRL_RESET    16'h0000
`define APHP_USER_RESET    16'h0000
// Timing in internal clock periods, results and host clock cycles.
`define APHP_WR_MIN_INTERNAL_CLOCK   4
`define APHP_ODR_INTERNAL_CLOCK      32
`define APHP_GD_RESULTS    8
`define APHP_HOLD_CYC      8
`define APHP_RD_CYC        4
`define APHP_GAP_CYC       4
// Host command port map.
`define APHP_H_CMD         3'h0
`define APHP_H_WADDR       3'h1
`define APHP_H_WDATA       3'h2
`define APHP_H_STAT        3'h3
`define APHP_H_RMSW        3'h4
`define APHP_H_RLSW        3'h5
`define APHP_CMD_RES       0
`define APHP_CMD_SINGLE    1
`define APHP_CMD_WRITE     2
`define APHP_BUS_IDLE      16'hFFFF
`endif

// ===== hdl/aphp_pkg.sv
package aphp_pkg;
    // Host sequencer states, one-hot.
    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_RD1  = 8'h02,
        ST_RGAP = 8'h04,
        ST_RD2  = 8'h08,
        ST_WA   = 8'h10,
        ST_WGAP = 8'h20,
        ST_WD   = 8'h40,
        ST_TAIL = 8'h80
    } aphp_state_t;
    // Word of a result that the next read returns.
    typedef enum logic {
        PH_MSW = 1'b0,
        PH_LSW = 1'b1
    } aphp_phase_t;
endpackage : aphp_pkg

// ===== hdl/aphp_if.sv
`timescale 1ns/1ps
`include "aphp_params.svh"
interface aphp_if;
    logic        cs_b;                  // Chip select, low active.
    logic        rw_sel;                // Low reads, high writes.
    logic [15:0] host_data;             // Host drive value.
    logic        host_oe;               // Host drives the bus.
    logic [15:0] dev_data;              // Device drive value.
    logic        dev_oe;                // Device drives the bus.
    logic        result_ready_strobe_b; // Result ready, low pulse.
    wire  [15:0] bus_data;              // Resolved bus level.
    // The bus rests high when nobody drives it.
    assign bus_data = dev_oe ? dev_data : (host_oe ? host_data : `APHP_BUS_IDLE);
    modport device (input cs_b, input rw_sel, input bus_data,
                    output dev_data, output dev_oe, output result_ready_strobe_b);
    modport host (output cs_b, output rw_sel, output host_data, output host_oe,
                  input bus_data, input result_ready_strobe_b);
endinterface : aphp_if

// ===== hdl/aphp_device.sv
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "aphp_params.svh"
module aphp_device
    import aphp_pkg::*;
#(
    parameter int ODR_INTERNAL_CLOCK   = `APHP_ODR_INTERNAL_CLOCK,
    parameter int GD_RESULTS = `APHP_GD_RESULTS
)
(
    // Clock and reset.
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    // Parallel port toward the host.
    aphp_if.device           port,
    // Conversion source and flags.
    input  wire logic [23:0] sample_in,
    input  wire logic        overrange_in,
    input  wire logic        filter_ok_in,
    input  wire logic        download_ok_in,
    // Configuration seen by the converter.
    output logic      [15:0] cfg_ctrl,
    output logic      [15:0] cfg_user,
    output logic             internal_clock_en
);
    // Refuse periods and delays that the counters cannot hold.
    if (ODR_INTERNAL_CLOCK < 2 || ODR_INTERNAL_CLOCK > 65535) begin : g_odr_chk
        $error("ODR_INTERNAL_CLOCK out of range");
    end
    if (GD_RESULTS < 1 || GD_RESULTS > 255) begin : g_gd_chk
        $error("GD_RESULTS out of range");
    end

    logic              div_ff;       // Divide-by-two phase.
    logic [15:0]       odr_cnt_ff;   // Internal clocks within one result period.
    logic [23:0]       result_ff;    // Output register for the latest result.
    logic              ovr_ff;       // Overrange state captured with the result.
    logic              strobe_b_ff;  // Ready strobe, low for one internal clock.
    logic [7:0]        gd_cnt_ff;    // Results seen since reset or last write.
    logic [15:0]       ctrl_ff;      // Control register.
    logic [15:0]       user_ff;      // General user register.
    aphp_phase_t       phase_ff;     // Which half of the result is next.
    logic              rd_prev_ff;   // Read active last cycle.
    logic              wr_prev_ff;   // Write active last cycle.
    logic              oe_ff;        // Device drives the bus.
    logic [15:0]       dout_ff;      // Word on the bus.
    logic [15:0]       wdata_ff;     // Word latched during a write.
    logic [2:0]        wlen_ff;      // Internal clocks seen in a write.
    logic              pend_ff;      // An address waits for its data.
    logic [15:0]       addr_ff;      // Latched register address.

    // Internal clock: every cycle when the select bit is one, else every other.
    wire clock_divide_select = ctrl_ff[`APHP_CTRL_CLOCK_DIVIDE_SELECT];
    assign internal_clock_en = clock_divide_select | div_ff;

    // Decoding of the host lines.
    wire rd_act   = ~port.cs_b & ~port.rw_sel;
    wire wr_act   = ~port.cs_b & port.rw_sel;
    wire rd_end   = rd_prev_ff & ~rd_act;
    wire wr_end   = wr_prev_ff & ~wr_act;
    wire wr_long  = (wlen_ff >= 3'(`APHP_WR_MIN_INTERNAL_CLOCK));
    wire wr_done  = wr_end & wr_long;
    wire commit   = wr_done & pend_ff;
    wire odr_last = (odr_cnt_ff == 16'(ODR_INTERNAL_CLOCK - 1));
    wire conv_tick = internal_clock_en & odr_last;
    wire valid    = (gd_cnt_ff == 8'(GD_RESULTS));
    wire rb_stat  = ctrl_ff[`APHP_CTRL_RB_STAT];
    wire rb_user  = ctrl_ff[`APHP_CTRL_RB_USER];

    // Status byte returned with the low result bits.
    wire [7:0] stat_byte = {valid, ovr_ff, ctrl_ff[`APHP_CTRL_USER_FILTER_FLAG],
                            ctrl_ff[`APHP_CTRL_LOW_POWER_FLAG], filter_ok_in,
                            download_ok_in, 2'b00};

    // Word selection for the next read.
    wire [15:0] res_word = (phase_ff == PH_MSW) ? result_ff[23:8]
                                                : {result_ff[7:0], stat_byte};
    wire [15:0] rd_word  = rb_stat ? {8'h00, stat_byte} :
                           (rb_user ? user_ff : res_word);

    // Outputs to the pins and to the converter.
    assign port.dev_data = dout_ff;
    assign port.dev_oe = oe_ff;
    assign port.result_ready_strobe_b = strobe_b_ff;
    assign cfg_ctrl = ctrl_ff;
    assign cfg_user = user_ff;

    // Clock divider phase runs freely.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            div_ff <= 1'b0;
        else
            div_ff <= ~div_ff;
    end

    // Result period counter starts at reset with no host help.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            odr_cnt_ff <= 16'h0000;
        else if (internal_clock_en)
            odr_cnt_ff <= odr_last ? 16'h0000 : odr_cnt_ff + 16'h0001;
    end

    // New result overwrites the output register and pulses the strobe.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            result_ff   <= 24'h000000;
            ovr_ff      <= 1'b0;
            strobe_b_ff <= 1'b1;
        end
        else if (conv_tick)
        begin
            result_ff   <= sample_in;
            ovr_ff      <= overrange_in;
            strobe_b_ff <= 1'b0;
        end
        else if (internal_clock_en)
            strobe_b_ff <= 1'b1;
    end

    // Group delay counter; a committed write restarts it.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            gd_cnt_ff <= 8'h00;
        else if (commit)
            gd_cnt_ff <= 8'h00;
        else if (conv_tick && !valid)
            gd_cnt_ff <= gd_cnt_ff + 8'h01;
    end

    // Edge tracking of the read and write windows.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_prev_ff <= 1'b0;
            wr_prev_ff <= 1'b0;
        end
        else
        begin
            rd_prev_ff <= rd_act;
            wr_prev_ff <= wr_act;
        end
    end

    // Bus drive: on one cycle after a read starts, off one cycle after it ends.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            oe_ff   <= 1'b0;
            dout_ff <= 16'h0000;
        end
        else
        begin
            oe_ff <= rd_act;
            if (rd_act)
                dout_ff <= rd_word;
        end
    end

    // Read half tracking; a new result always restarts at the upper word.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            phase_ff <= PH_MSW;
        else if (conv_tick)
            phase_ff <= PH_MSW;
        else if (rd_end && !rb_stat && !rb_user)
            phase_ff <= (phase_ff == PH_MSW) ? PH_LSW : PH_MSW;
    end

    // Write window: latch the bus and count internal clocks while chip select is low.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wdata_ff <= 16'h0000;
            wlen_ff  <= 3'h0;
        end
        else if (wr_act)
        begin
            wdata_ff <= port.bus_data;
            if (internal_clock_en && !wr_long)
                wlen_ff <= wlen_ff + 3'h1;
        end
        else
            wlen_ff <= 3'h0;
    end

    // Address then data; any read throws a waiting address away.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pend_ff <= 1'b0;
            addr_ff <= 16'h0000;
        end
        else if (rd_act)
            pend_ff <= 1'b0;
        else if (wr_done && !pend_ff)
        begin
            addr_ff <= wdata_ff;
            pend_ff <= 1'b1;
        end
        else if (commit)
            pend_ff <= 1'b0;
    end

    // Register file; a readback select bit is spent by the read it serves.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl_ff <= `APHP_CTRL_RESET;
            user_ff <= `APHP_USER_RESET;
        end
        else if (commit && addr_ff == `APHP_REG_CTRL)
            ctrl_ff <= wdata_ff;
        else if (commit && addr_ff == `APHP_REG_USER)
            user_ff <= wdata_ff;
        else if (rd_end)
        begin
            ctrl_ff[`APHP_CTRL_RB_STAT] <= 1'b0;
            ctrl_ff[`APHP_CTRL_RB_USER] <= 1'b0;
        end
    end
endmodule : aphp_device

// ===== hdl/aphp_host.sv
`timescale 1ns/1ps
`include "aphp_params.svh"
module aphp_host
    import aphp_pkg::*;
#(
    parameter int HOLD_CYC = `APHP_HOLD_CYC,
    parameter int RD_CYC   = `APHP_RD_CYC,
    parameter int GAP_CYC  = `APHP_GAP_CYC
)
(
    // Clock and reset.
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    // Parallel port toward the device.
    aphp_if.host             port,
    // Software command port.
    input  wire logic [2:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata
);
    // Refuse counts the counter cannot hold.
    if (HOLD_CYC < 1 || HOLD_CYC > 255 || RD_CYC < 2 || RD_CYC > 255 ||
        GAP_CYC < 1 || GAP_CYC > 255) begin : g_cnt_chk
        $error("host timing parameter out of range");
    end

    aphp_state_t st_ff, nxt_st;        // Sequencer state.
    logic [7:0]  cnt_ff, nxt_cnt;      // Cycles left in the current state.
    logic        single_ff;            // Current read is a single readback.
    logic [15:0] waddr_ff;             // Register address to write.
    logic [15:0] wdat_ff;              // Register data to write.
    logic [15:0] rmsw_ff;              // First word read.
    logic [15:0] rlsw_ff;              // Second word read.
    logic        invalid_ff;           // Strobe seen during a read.
    logic        done_ff;              // Last command finished.
    logic [15:0] rdata_ff;             // Read data, one cycle after strobe.

    // Command decode.
    wire cmd_wr  = wr && addr == `APHP_H_CMD;
    wire idle    = (st_ff == ST_IDLE);
    wire go_res  = cmd_wr & idle & wdata[`APHP_CMD_RES];
    wire go_sing = cmd_wr & idle & wdata[`APHP_CMD_SINGLE];
    wire go_wr   = cmd_wr & idle & wdata[`APHP_CMD_WRITE];
    wire last    = (cnt_ff == 8'h00);
    wire reading = (st_ff == ST_RD1) | (st_ff == ST_RD2);
    wire writing = (st_ff == ST_WA) | (st_ff == ST_WD);

    // Pin drive follows the state; both lines high between accesses.
    assign port.cs_b = ~(reading | writing);
    assign port.rw_sel = ~reading;
    assign port.host_oe = writing;
    assign port.host_data = (st_ff == ST_WA) ? waddr_ff : wdat_ff;
    assign rdata = rdata_ff;

    // Sequencer next state.
    always_comb
    begin
        nxt_st  = st_ff;
        nxt_cnt = last ? 8'h00 : cnt_ff - 8'h01;
        case (st_ff)
            ST_IDLE:
            begin
                if (go_res || go_sing)
                begin
                    nxt_st  = ST_RD1;
                    nxt_cnt = 8'(RD_CYC - 1);
                end
                else if (go_wr)
                begin
                    nxt_st  = ST_WA;
                    nxt_cnt = 8'(HOLD_CYC - 1);
                end
            end
            ST_RD1:
                if (last)
                begin
                    nxt_st  = single_ff ? ST_TAIL : ST_RGAP;
                    nxt_cnt = single_ff ? 8'(HOLD_CYC - 1) : 8'(GAP_CYC - 1);
                end
            ST_RGAP:
                if (last)
                begin
                    nxt_st  = ST_RD2;
                    nxt_cnt = 8'(RD_CYC - 1);
                end
            ST_RD2:
                if (last)
                begin
                    nxt_st  = ST_TAIL;
                    nxt_cnt = 8'(HOLD_CYC - 1);
                end
            ST_WA:
                if (last)
                begin
                    nxt_st  = ST_WGAP;
                    nxt_cnt = 8'(HOLD_CYC - 1);
                end
            ST_WGAP:
                if (last)
                begin
                    nxt_st  = ST_WD;
                    nxt_cnt = 8'(HOLD_CYC - 1);
                end
            ST_WD:
                if (last)
                begin
                    nxt_st  = ST_TAIL;
                    nxt_cnt = 8'(HOLD_CYC - 1);
                end
            ST_TAIL:
                if (last)
                    nxt_st = ST_IDLE;
            default:
            begin
                nxt_st  = ST_IDLE;
                nxt_cnt = 8'h00;
            end
        endcase
    end

    // Sequencer registers.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_ff  <= ST_IDLE;
            cnt_ff <= 8'h00;
        end
        else
        begin
            st_ff  <= nxt_st;
            cnt_ff <= nxt_cnt;
        end
    end

    // Captured words and flags; the strobe set wins over a new command's clear.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            single_ff  <= 1'b0;
            rmsw_ff    <= 16'h0000;
            rlsw_ff    <= 16'h0000;
            invalid_ff <= 1'b0;
            done_ff    <= 1'b0;
        end
        else
        begin
            if (go_res || go_sing)
                single_ff <= go_sing & ~go_res;
            if (st_ff == ST_RD1 && last)
                rmsw_ff <= port.bus_data;
            if (st_ff == ST_RD2 && last)
                rlsw_ff <= port.bus_data;
            if (reading && !port.result_ready_strobe_b)
                invalid_ff <= 1'b1;
            else if (go_res || go_sing || go_wr)
                invalid_ff <= 1'b0;
            if (st_ff == ST_TAIL && last)
                done_ff <= 1'b1;
            else if (go_res || go_sing || go_wr)
                done_ff <= 1'b0;
        end
    end

    // Software register writes and the read data path.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            waddr_ff <= 16'h0000;
            wdat_ff  <= 16'h0000;
            rdata_ff <= 16'h0000;
        end
        else
        begin
            if (wr && addr == `APHP_H_WADDR)
                waddr_ff <= wdata;
            if (wr && addr == `APHP_H_WDATA)
                wdat_ff <= wdata;
            if (rd)
            begin
                case (addr)
                    `APHP_H_STAT: rdata_ff <= {13'h0000, ~idle, invalid_ff, done_ff};
                    `APHP_H_RMSW: rdata_ff <= rmsw_ff;
                    `APHP_H_RLSW: rdata_ff <= rlsw_ff;
                    `APHP_H_WADDR: rdata_ff <= waddr_ff;
                    `APHP_H_WDATA: rdata_ff <= wdat_ff;
                    default: rdata_ff <= 16'h0000;
                endcase
            end
        end
    end
endmodule : aphp_host

// ===== dv/aphp_sva.sv
`timescale 1ns/1ps
// Watches the parallel link where the host end and the device end meet.
module aphp_chk (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_b,
    // Select lines from the host.
    input wire logic cs_b,
    input wire logic rw_sel,
    // Bus drive enables of both ends.
    input wire logic host_oe,
    input wire logic dev_oe,
    // Result ready pulse from the device.
    input wire logic result_ready_strobe_b
);
    // Every check runs on the one clock and sleeps during reset.
    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    // A read is active while both select lines are low.
    wire logic rd_act = !cs_b && !rw_sel;

    a_strobe_short : assert property (
        $fell(result_ready_strobe_b) |-> ##[1:2] result_ready_strobe_b)
        else $error("ready strobe held low too long");
    a_drive_read : assert property (
        rd_act |=> dev_oe)
        else $error("device did not drive a read");
    a_release_bus : assert property (
        !rd_act |=> !dev_oe)
        else $error("device kept the bus after a read");
    a_no_contend : assert property (
        !(dev_oe && host_oe))
        else $error("both ends drive the bus");
    a_write_drive : assert property (
        (!cs_b && rw_sel) |-> host_oe)
        else $error("host left the bus during a write");
    a_write_len : assert property (
        ($fell(cs_b) && rw_sel) |-> (!cs_b) [*8])
        else $error("write select shorter than four internal clocks");
    a_write_gap : assert property (
        ($rose(cs_b) && $past(rw_sel)) |-> cs_b [*8])
        else $error("gap after a write too short");
    a_read_gap : assert property (
        ($rose(cs_b) && !$past(rw_sel)) |-> (cs_b && rw_sel) [*2])
        else $error("gap after a read too short");
    a_read_len : assert property (
        ($fell(cs_b) && !rw_sel) |-> rd_act [*4])
        else $error("read select too short");
endmodule : aphp_chk

// ===== dv/tb_top.sv
`timescale 1ns/1ps
`include "aphp_params.svh"
module tb_top;
    // One expected read value, its mask and a label.
    typedef struct {
        string       nm;
        logic [15:0] val;
        logic [15:0] msk;
    } aphp_exp_t;

    logic        ref_clk;        // Bench clock.
    logic        rst_b;          // Reset, low active.
    logic [2:0]  addr;           // Command port address.
    logic [15:0] wdata;          // Command port write data.
    logic        wr;             // Command port write strobe.
    logic        rd;             // Command port read strobe.
    logic [15:0] rdata;          // Command port read data.
    logic [23:0] sample_in;      // Conversion source.
    logic        overrange_in;   // Overrange flag source.
    logic        filter_ok_in;   // Filter flag source.
    logic        download_ok_in; // Download flag source.
    logic [15:0] cfg_ctrl;       // Device control register.
    logic [15:0] cfg_user;       // Device user register.
    logic        internal_clock_en;        // Internal clock enable.
    logic        rd_d;           // Read strobe one cycle late.
    logic [31:0] rnd;            // Random generator state.
    int          n_mismatch;     // Mismatches seen.
    int          n_checks;       // Comparisons made.
    aphp_exp_t   exp_q[$];       // Notes of expected reads.
    aphp_exp_t   e_cur;          // Note under comparison.

    aphp_if u_aphp_if ();

    aphp_device #(.GD_RESULTS(3)) u_aphp_device (
        .ref_clk(ref_clk), .rst_b(rst_b), .port(u_aphp_if),
        .sample_in(sample_in), .overrange_in(overrange_in),
        .filter_ok_in(filter_ok_in), .download_ok_in(download_ok_in),
        .cfg_ctrl(cfg_ctrl), .cfg_user(cfg_user), .internal_clock_en(internal_clock_en));

    aphp_host u_aphp_host (
        .ref_clk(ref_clk), .rst_b(rst_b), .port(u_aphp_if),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));

    aphp_chk u_aphp_chk (
        .ref_clk(ref_clk), .rst_b(rst_b), .cs_b(u_aphp_if.cs_b),
        .rw_sel(u_aphp_if.rw_sel), .host_oe(u_aphp_if.host_oe),
        .dev_oe(u_aphp_if.dev_oe), .result_ready_strobe_b(u_aphp_if.result_ready_strobe_b));

    // The clock toggles every half period of 100 ns.
    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // Next state of the random generator.
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr

    // Compares one value and reports a difference.
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrap_up

    // A wait that ran out counts as a mismatch and closes the run.
    task automatic fail(input string nm);
        n_mismatch++;
        $display("wrong value %s expected event seen timeout", nm);
        wrap_up();
    endtask : fail

    // One-cycle write on the command port.
    task automatic hw(input logic [2:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge ref_clk);
        wr    <= 1'b0;
    endtask : hw

    // One-cycle read; the expected value goes to the monitor's queue.
    task automatic hr(input logic [2:0] a, input string nm, input logic [15:0] v, input logic [15:0] m);
        @(posedge ref_clk);
        addr <= a;
        rd   <= 1'b1;
        exp_q.push_back('{nm, v, m});
        @(posedge ref_clk);
        rd   <= 1'b0;
    endtask : hr

    // Polls the status word until the host is idle with done set.
    task automatic wait_done;
        int i;
        for (i = 0; i < 200; i++)
        begin
            hr(`APHP_H_STAT, "status", 16'h0000, 16'h0000);
            #1;
            if (rdata[0] === 1'b1 && rdata[2] === 1'b0)
                return;
        end
        fail("done");
    endtask : wait_done

    // Waits for one complete ready pulse.
    task automatic wait_strobe;
        int i;
        i = 0;
        while (u_aphp_if.result_ready_strobe_b !== 1'b0 && i < 300)
        begin
            @(posedge ref_clk);
            i++;
        end
        while (u_aphp_if.result_ready_strobe_b !== 1'b1 && i < 300)
        begin
            @(posedge ref_clk);
            i++;
        end
        if (i >= 300)
            fail("ready strobe");
    endtask : wait_strobe

    // Programs a device register: address word, data word, then the command.
    task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
        hw(`APHP_H_WADDR, a);
        hw(`APHP_H_WDATA, d);
        hw(`APHP_H_CMD, 16'h0004);
        wait_done();
    endtask : wr_reg

    // Puts fresh random values on the conversion source.
    task automatic stim;
        rnd = lfsr(rnd);
        @(posedge ref_clk);
        sample_in      <= rnd[23:0];
        overrange_in   <= rnd[24];
        filter_ok_in   <= rnd[25];
        download_ok_in <= rnd[26];
    endtask : stim

    // Reads one result as two words and notes what each must hold.
    task automatic read_pair(input logic vld, input logic [15:0] ctl);
        hw(`APHP_H_CMD, 16'h0001);
        wait_done();
        hr(`APHP_H_RMSW, "upper word", sample_in[23:8], 16'hFFFF);
        hr(`APHP_H_RLSW, "lower word", {sample_in[7:0], vld, overrange_in, ctl[2], ctl[1],
           filter_ok_in, download_ok_in, 2'b00}, 16'hFFFF);
    endtask : read_pair

    // Monitor: each read answer takes the oldest note and is compared with it unless its mask is zero.
    always @(posedge ref_clk)
    begin
        if (rd_d && exp_q.size() > 0)
        begin
            e_cur = exp_q.pop_front();
            if (e_cur.msk != 16'h0000)
                check(e_cur.nm, rdata & e_cur.msk, e_cur.val & e_cur.msk);
        end
        rd_d <= rd;
    end

    // Main sequence.
    initial
    begin
        logic        ie;
        logic [15:0] v;
        int          k;
        rst_b = 1'b0;
        addr = 3'h0;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        rd_d = 1'b0;
        sample_in = 24'h000000;
        overrange_in = 1'b0;
        filter_ok_in = 1'b0;
        download_ok_in = 1'b0;
        n_mismatch = 0;
        n_checks = 0;
        rnd = 32'hC864;
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        #1;
        check("ctrl reset", cfg_ctrl, 16'h0000);
        check("user reset", cfg_user, 16'h0000);
        ie = internal_clock_en;
        @(posedge ref_clk);
        #1;
        check("half rate enable", {15'h0000, internal_clock_en}, {15'h0000, ~ie});
        // Pairs with default settings, then just after a control write.
        for (k = 0; k < 2; k++)
        begin
            stim();
            if (k == 1)
                wr_reg(`APHP_REG_CTRL, 16'h0006);
            repeat (k == 1 ? 1 : 5) wait_strobe();
            read_pair(k == 0, k == 1 ? 16'h0006 : 16'h0000);
        end
        // User register written, then read back through the control select.
        stim();
        v = rnd[15:0];
        wr_reg(`APHP_REG_USER, v);
        check("user reg", cfg_user, v);
        wr_reg(`APHP_REG_CTRL, 16'h0010);
        hw(`APHP_H_CMD, 16'h0002);
        wait_done();
        hr(`APHP_H_RMSW, "readback", v, 16'hFFFF);
        #1;
        check("readback select", cfg_ctrl, 16'h0000);
        // Status readback right after a write: valid is still clear.
        wr_reg(`APHP_REG_CTRL, 16'h0008);
        hw(`APHP_H_CMD, 16'h0002);
        wait_done();
        hr(`APHP_H_RMSW, "status readback", {9'h000, overrange_in, 2'b00, filter_ok_in,
           download_ok_in, 2'b00}, 16'hFFFF);
        hr(3'h6, "unmapped", 16'h0000, 16'hFFFF);
        // A ready pulse lands inside a read pair.
        wait_strobe();
        repeat (50) @(posedge ref_clk);
        hw(`APHP_H_CMD, 16'h0001);
        wait_done();
        hr(`APHP_H_STAT, "invalid flag", 16'h0003, 16'h0007);
        // Full rate internal clock.
        wr_reg(`APHP_REG_CTRL, 16'h0001);
        check("ctrl full rate", cfg_ctrl, 16'h0001);
        for (k = 0; k < 3; k++)
        begin
            @(posedge ref_clk);
            #1;
            check("full rate enable", {15'h0000, internal_clock_en}, 16'h0001);
        end
        repeat (4) @(posedge ref_clk);
        wrap_up();
    end
endmodule : tb_top
